// ---- design/uscb_top.sv ----
// Summary of operation
// RULE1 - tx empty flag raises irq when enabled
// RULE2 - tx done flag raises irq when enabled
// RULE3 - overrun or rx full share rx enable
// RULE4 - idle flag raises irq when enabled
// RULE5 - tx_on off-on pulse queues one preamble
// RULE6 - one bit period wait after tx_on
// RULE7 - pin released unless enabled since first set
// RULE8 - rx_on enables start bit hunting
// RULE9 - mute bit, hardware clears on wake-up
// RULE10 - software receives data before muting
// RULE11 - break while set, one more after clear
// RULE12 - data address splits tx/rx holding
// RULE13 - coarse prescale 1, 3, 4, 13 shared
// RULE14 - tx power-of-two divide
// RULE15 - rx power-of-two divide
// RULE16 - nonzero rx extended divisor applies
// RULE17 - nonzero tx extended divisor applies
// RULE18 - registers reset to zero; status here resets to 0xC0 (tx empty, tx done set)
// RULE19 - tx empty set on move, cleared by sequence
// RULE20 - one irq line, gated by cpu mask
// RULE21 - rate is clock/16/prescale/pow/ext
// RULE22 - independent tx and rx chains
`timescale 1ns/1ps
`include "uscb_defines.svh"
module uscb_top
	import uscb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdData,
	input wire logic cpuIrqMask,
	output logic serialIrq,
	input wire logic rxPin,
	output logic txPin,
	output logic txPinOwn
);
	uscb_state_t st_r; // registered state
	uscb_state_t st_nxt; // next state
	logic preTick; // coarse prescaler output
	logic txPowTick; // tx power-of-two output
	logic rxPowTick; // rx power-of-two output
	logic tx16Tick; // tx oversample tick
	logic rx16Tick; // rx oversample tick
	logic txBitTick; // tx bit boundary
	logic [3:0] preLast; // coarse last count
	logic [6:0] txMask; // tx divider mask
	logic [6:0] rxMask; // rx divider mask
	logic txSlot; // tx may start a frame
	logic wrCtrl; // control write this cycle
	logic [7:0] ctrlNew; // value being written

	// coarse factor decode, shared by both directions
	always_comb
	begin
		unique case (st_r.baud[`USCB_CDS_HI:`USCB_CDS_LO]) // RULE13
			2'b00: preLast = `USCB_PR_1;
			2'b01: preLast = `USCB_PR_3;
			2'b10: preLast = `USCB_PR_4;
			2'b11: preLast = `USCB_PR_13;
		endcase
	end

	// low code bits all ones give a divide by two to the code
	assign txMask = 7'(8'hFF >> (4'h8 - {1'b0, st_r.baud[`USCB_TXS_HI:`USCB_TXS_LO]}));
	assign rxMask = 7'(8'hFF >> (4'h8 - {1'b0, st_r.baud[`USCB_RXS_HI:`USCB_RXS_LO]}));
	assign preTick = st_r.preCnt == preLast; // RULE13
	assign txPowTick = preTick && ((st_r.txPow & txMask) == txMask); // RULE14
	assign rxPowTick = preTick && ((st_r.rxPow & rxMask) == rxMask); // RULE15
	// extended divisor sits after the power stage; zero bypasses it
	assign tx16Tick = txPowTick && (st_r.txExt == `USCB_EXT_RST
		|| st_r.txExtCnt == st_r.txExt - 8'h01); // RULE17
	assign rx16Tick = rxPowTick && (st_r.rxExt == `USCB_EXT_RST
		|| st_r.rxExtCnt == st_r.rxExt - 8'h01); // RULE16
	// sixteen oversample ticks make one bit
	assign txBitTick = tx16Tick && st_r.txPhase == `USCB_PHASE_LAST; // RULE21
	assign txSlot = txBitTick && (st_r.txState == TX_IDLE
		|| (st_r.txState == TX_SHIFT && st_r.txBits == `USCB_FRAME_LAST));
	assign wrCtrl = busWr && busAddr == `USCB_OFS_CTRL2;
	assign ctrlNew = busWrData;

	// next state of the whole block
	always_comb
	begin
		st_nxt = st_r;
		// divider chains: one shared prescale counter, then each direction its own counters
		st_nxt.preCnt = preTick ? 4'h0 : st_r.preCnt + 4'h1; // RULE13
		if (preTick)
		begin
			st_nxt.txPow = st_r.txPow + 7'h01; // RULE22
			st_nxt.rxPow = st_r.rxPow + 7'h01; // RULE22
		end
		if (txPowTick)
		begin
			// counter only matters while a divisor is set
			st_nxt.txExtCnt = tx16Tick ? 8'h00 : st_r.txExtCnt + 8'h01; // RULE17
		end
		if (rxPowTick)
		begin
			st_nxt.rxExtCnt = rx16Tick ? 8'h00 : st_r.rxExtCnt + 8'h01; // RULE16
		end
		st_nxt.txPhase = st_r.txPhase + {3'h0, tx16Tick}; // RULE21

		// register reads, answered in the next cycle
		if (busRd)
		begin
			unique case (busAddr)
				`USCB_OFS_STATUS:
				begin
					st_nxt.rdData = {st_r.txEmpty, st_r.txDone, st_r.rxFull,
						st_r.idle, st_r.overrun, 3'h0};
					// first half of both clearing sequences
					st_nxt.txArm = 1'b1;
					st_nxt.rxArm = 1'b1;
				end
				`USCB_OFS_DATA:
				begin
					st_nxt.rdData = st_r.rxHold; // RULE12
					if (st_r.rxArm)
					begin
						st_nxt.rxFull = 1'b0;
						st_nxt.overrun = 1'b0;
						st_nxt.idle = 1'b0;
						st_nxt.rxArm = 1'b0;
					end
				end
				`USCB_OFS_BAUD: st_nxt.rdData = st_r.baud;
				`USCB_OFS_CTRL2: st_nxt.rdData = st_r.ctrl;
				`USCB_OFS_RXEXT: st_nxt.rdData = st_r.rxExt;
				`USCB_OFS_TXEXT: st_nxt.rdData = st_r.txExt;
				default: st_nxt.rdData = 8'h00; // unmapped reads zero
			endcase
		end

		// register writes
		if (busWr)
		begin
			unique case (busAddr)
				`USCB_OFS_DATA:
				begin
					st_nxt.txHold = busWrData; // RULE12
					if (st_r.txArm)
					begin
						st_nxt.txEmpty = 1'b0; // RULE19
						st_nxt.txDone = 1'b0;
						st_nxt.txArm = 1'b0;
					end
				end
				`USCB_OFS_BAUD: st_nxt.baud = busWrData;
				`USCB_OFS_CTRL2: st_nxt.ctrl = ctrlNew;
				`USCB_OFS_RXEXT: st_nxt.rxExt = busWrData; // RULE16
				`USCB_OFS_TXEXT: st_nxt.txExt = busWrData; // RULE17
				default: ; // status and gaps ignore writes
			endcase
		end

		// transmitter; a frame in flight always finishes
		unique case (st_r.txState)
			TX_IDLE: ; // waits for a slot
			TX_DELAY:
			begin
				if (txBitTick)
				begin
					st_nxt.txState = TX_IDLE; // RULE6
				end
			end
			TX_SHIFT:
			begin
				if (txBitTick && st_r.txBits != `USCB_FRAME_LAST)
				begin
					st_nxt.txShift = {1'b1, st_r.txShift[9:1]};
					st_nxt.txBits = st_r.txBits + 4'h1;
				end
			end
		endcase
		if (txSlot)
		begin
			// done flag only after a data frame; the set beats a clear
			st_nxt.txDone = st_nxt.txDone || (st_r.txState == TX_SHIFT && st_r.isData);
			st_nxt.txState = TX_IDLE;
			st_nxt.txBits = 4'h0;
			// disabled: nothing new starts
			if (st_r.ctrl[`USCB_TXON] && (st_r.ctrl[`USCB_BRK] || st_r.pendBrk))
			begin
				st_nxt.txShift = 10'h000; // RULE11
				st_nxt.pendBrk = 1'b0;
				st_nxt.isData = 1'b0;
				st_nxt.txState = TX_SHIFT;
			end
			else if (st_r.ctrl[`USCB_TXON] && st_r.pendPre)
			begin
				st_nxt.txShift = 10'h3FF; // RULE5
				st_nxt.pendPre = 1'b0;
				st_nxt.isData = 1'b0;
				st_nxt.txState = TX_SHIFT;
			end
			else if (st_r.ctrl[`USCB_TXON] && !st_r.txEmpty)
			begin
				// holding moves only while the empty flag is clear
				st_nxt.txShift = {1'b1, st_r.txHold, 1'b0}; // RULE19
				st_nxt.txEmpty = 1'b1; // RULE19
				st_nxt.isData = 1'b1;
				st_nxt.txState = TX_SHIFT;
			end
		end

		// receiver
		if (!st_r.ctrl[`USCB_RXON])
		begin
			st_nxt.rxState = RX_HUNT; // RULE8
			st_nxt.idleCnt = 8'h00;
		end
		else if (rx16Tick)
		begin
			st_nxt.rxPhase = st_r.rxPhase + 4'h1;
			unique case (st_r.rxState)
				RX_HUNT:
				begin
					st_nxt.rxPhase = 4'h0;
					if (!rxPin)
					begin
						st_nxt.rxState = RX_START; // RULE8
						st_nxt.idleCnt = 8'h00;
					end
					else if (st_r.idleCnt == `USCB_IDLE_TICKS)
					begin
						// a full frame of marks; only once per byte
						st_nxt.idleCnt = 8'h00;
						if (st_r.idleArm)
						begin
							st_nxt.idleArm = 1'b0;
							// muted: the idle line is the wake-up, no flag
							st_nxt.ctrl[`USCB_MUTE] = 1'b0; // RULE9
							st_nxt.idle = st_nxt.idle || !st_r.ctrl[`USCB_MUTE];
						end
					end
					else
					begin
						st_nxt.idleCnt = st_r.idleCnt + 8'h01;
					end
				end
				RX_START:
				begin
					// mid start bit check rejects glitches
					if (st_r.rxPhase == `USCB_PHASE_MID)
					begin
						st_nxt.rxPhase = 4'h0;
						st_nxt.rxBits = 4'h0;
						st_nxt.rxState = rxPin ? RX_HUNT : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (st_r.rxPhase == `USCB_PHASE_LAST)
					begin
						st_nxt.rxBits = st_r.rxBits + 4'h1;
						if (st_r.rxBits != `USCB_DATA_BITS)
						begin
							st_nxt.rxShift = {rxPin, st_r.rxShift[7:1]};
						end
						else
						begin
							// stop bit: deliver unless muted; overrun instead while holding still full
							st_nxt.rxState = RX_HUNT;
							st_nxt.idleArm = 1'b1;
							if (!st_r.ctrl[`USCB_MUTE] && st_r.rxFull)
							begin
								st_nxt.overrun = 1'b1; // holding kept
							end
							else if (!st_r.ctrl[`USCB_MUTE])
							begin
								st_nxt.rxHold = st_r.rxShift; // RULE12
								st_nxt.rxFull = 1'b1;
							end
						end
					end
				end
			endcase
		end
		// control edges, decided against the old value after the
		// transmitter so that a slot in the same cycle cannot undo them
		if (wrCtrl)
		begin
			st_nxt.txEver = st_r.txEver || ctrlNew[`USCB_TXON]; // RULE7
			if (ctrlNew[`USCB_TXON] && !st_r.ctrl[`USCB_TXON])
			begin
				// mid-frame re-enable queues an idle frame
				if (st_r.txState == TX_SHIFT)
				begin
					st_nxt.pendPre = 1'b1; // RULE5
				end
				else
				begin
					st_nxt.txState = TX_DELAY; // RULE6
				end
			end
			st_nxt.pendBrk = st_nxt.pendBrk
				|| (!ctrlNew[`USCB_BRK] && st_r.ctrl[`USCB_BRK]); // RULE11
			// software write of the mute bit wins over the wake-up
			st_nxt.ctrl[`USCB_MUTE] = ctrlNew[`USCB_MUTE]; // RULE9
		end
	end

	// state register; everything resets to constants
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '0; // RULE18
			st_r.txEmpty <= 1'b1;
			st_r.txDone <= 1'b1;
			st_r.txShift <= 10'h3FF;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign busRdData = st_r.rdData;
	assign txPin = st_r.txState == TX_SHIFT ? st_r.txShift[0] : 1'b1;
	// pin stays with the port until the transmitter was used
	assign txPinOwn = st_r.txEver
		&& (st_r.ctrl[`USCB_TXON] || st_r.ctrl[`USCB_RXON]); // RULE7
	// one shared line, held off while the cpu masks
	assign serialIrq = !cpuIrqMask && ( // RULE20
		(st_r.ctrl[`USCB_TIE] && st_r.txEmpty) // RULE1
		|| (st_r.ctrl[`USCB_TX_DONE_IRQ_EN] && st_r.txDone) // RULE2
		|| (st_r.ctrl[`USCB_RIE] && (st_r.overrun || st_r.rxFull)) // RULE3
		|| (st_r.ctrl[`USCB_IDLE_IRQ_EN] && st_r.idle)); // RULE4
endmodule : uscb_top

// ---- design/uscb_defines.svh ----
`ifndef USCB_DEFINES_SVH
`define USCB_DEFINES_SVH
// register offsets
`define USCB_OFS_STATUS 3'h0
`define USCB_OFS_DATA 3'h1
`define USCB_OFS_BAUD 3'h2
`define USCB_OFS_CTRL2 3'h4
`define USCB_OFS_RXEXT 3'h5
`define USCB_OFS_TXEXT 3'h7
// serial_control_two bit positions
`define USCB_TIE 7
`define USCB_TX_DONE_IRQ_EN 6
`define USCB_RIE 5
`define USCB_IDLE_IRQ_EN 4
`define USCB_TXON 3
`define USCB_RXON 2
`define USCB_MUTE 1
`define USCB_BRK 0
// bit_rate_select field positions
`define USCB_CDS_HI 7
`define USCB_CDS_LO 6
`define USCB_TXS_HI 5
`define USCB_TXS_LO 3
`define USCB_RXS_HI 2
`define USCB_RXS_LO 0
// reset values
`define USCB_CTRL_RST 8'h00
`define USCB_BAUD_RST 8'h00
`define USCB_EXT_RST 8'h00
// last prescale count for factors 1, 3, 4 and 13
`define USCB_PR_1 4'h0
`define USCB_PR_3 4'h2
`define USCB_PR_4 4'h3
`define USCB_PR_13 4'hC
// oversampling and frame timing
`define USCB_PHASE_LAST 4'hF
`define USCB_PHASE_MID 4'h7
`define USCB_FRAME_LAST 4'h9
`define USCB_DATA_BITS 4'h8
`define USCB_IDLE_TICKS 8'h9F
`endif

// ---- design/uscb_pkg.sv ----
package uscb_pkg;
	// transmitter sequence, gray along idle-delay-shift
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DELAY = 2'b01,
		TX_SHIFT = 2'b11
	} uscb_tx_t;
	// receiver sequence, gray along hunt-start-data
	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11
	} uscb_rx_t;
	// all state of the block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] baud;
		logic [7:0] rxExt;
		logic [7:0] txExt;
		logic [7:0] txHold;
		logic [7:0] rxHold;
		logic [7:0] rdData;
		logic txEmpty;
		logic txDone;
		logic rxFull;
		logic overrun;
		logic idle;
		logic txArm;
		logic rxArm;
		logic txEver;
		logic pendPre;
		logic pendBrk;
		logic isData;
		logic idleArm;
		logic [3:0] preCnt;
		logic [6:0] txPow;
		logic [6:0] rxPow;
		logic [7:0] txExtCnt;
		logic [7:0] rxExtCnt;
		logic [3:0] txPhase;
		logic [3:0] rxPhase;
		uscb_tx_t txState;
		logic [9:0] txShift;
		logic [3:0] txBits;
		uscb_rx_t rxState;
		logic [7:0] rxShift;
		logic [3:0] rxBits;
		logic [7:0] idleCnt;
	} uscb_state_t;
endpackage : uscb_pkg

// ---- testbench/uscb_top_asserts.sv ----
`timescale 1ns/1ps
module uscb_top_asserts
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [7:0] busRdData,
	input wire logic cpuIrqMask,
	input wire logic serialIrq,
	input wire logic txPin,
	input wire logic txPinOwn
);
	logic [7:0] shadow_r [8]; // bus-side copy of writable registers
	logic txEver_r; // tx_on written high since reset
	logic [7:0] ctrl; // copy of serial_control_two
	assign ctrl = shadow_r[4];
	// offsets 0, 1, 3 and 6 never hold a value here
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
		begin
			for (int i = 0; i < 8; i++)
				shadow_r[i] <= 8'h00;
			txEver_r <= 1'b0;
		end
		else if (busWr && busAddr inside {3'h2, 3'h4, 3'h5, 3'h7})
		begin
			shadow_r[busAddr] <= busWrData;
			if (busAddr == 3'h4 && busWrData[3])
				txEver_r <= 1'b1;
		end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	irq_masked_a: assert property (cpuIrqMask |-> !serialIrq)
		else $error("irq raised while masked");
	irq_gate_a: assert property (ctrl[7:4] == 4'h0 |-> !serialIrq)
		else $error("irq raised with all sources off");
	pin_free_a: assert property (!txEver_r || ctrl[3:2] == 2'b00 |-> !txPinOwn)
		else $error("tx pin held while released");
	pin_own_a: assert property (txEver_r && ctrl[3:2] != 2'b00 |-> txPinOwn)
		else $error("tx pin not owned");
	tx_delay_a: assert property ($rose(txEver_r) |-> txPin [*8])
		else $error("frame started without a bit delay");
	tx_quiet_a: assert property (!txEver_r |-> txPin)
		else $error("tx line active before enable");
	// mute bit masked: hardware may clear it on wake-up
	reg_read_a: assert property (busRd && busAddr > 3'h1 |=>
		((busRdData ^ $past(shadow_r[busAddr])) & 8'hFD) == 8'h00)
		else $error("register read mismatch");
	rdata_hold_a: assert property (!busRd |=> $stable(busRdData))
		else $error("read data changed without a read");
endmodule : uscb_top_asserts
bind uscb_top uscb_top_asserts chk (.clk_sys, .resetn, .busAddr, .busWrData, .busWr,
	.busRd, .busRdData, .cpuIrqMask, .serialIrq, .txPin, .txPinOwn);

// ---- testbench/uscb_remote.sv ----
`timescale 1ns/1ps
module uscb_remote
(
	input wire logic clk_sys,
	input wire logic txPin,
	input int bitLen,
	output logic rxPin
);
	logic [7:0] gotByte; // last byte taken off the tx line
	int lowLen; // first low run of the last frame, cycles
	int frames; // tx frames seen
	// one frame at len cycles a bit; line rests high between frames
	task automatic send(input logic [7:0] d, input int len);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxPin <= f[i];
			repeat (len) @(posedge clk_sys);
		end
	endtask : send
	// decoder samples on the falling edge, clear of the design's updates
	initial
	begin
		rxPin = 1'b1;
		frames = 0;
		forever
		begin
			@(negedge txPin);
			lowLen = 0;
			@(negedge clk_sys);
			while (!txPin && lowLen < 99999)
			begin
				lowLen++;
				@(negedge clk_sys);
			end
			repeat (bitLen / 2) @(negedge clk_sys);
			for (int i = 0; i < 8; i++)
			begin
				gotByte[i] = txPin;
				repeat (bitLen) @(negedge clk_sys);
			end
			frames++;
		end
	end
endmodule : uscb_remote

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic clk_sys, resetn, busWr, busRd, cpuIrqMask, rxPin, txPin, txPinOwn, serialIrq;
	logic [2:0] busAddr;
	logic [7:0] busWrData, busRdData;
	int bitLen, checked, failCount;
	logic [7:0] br [4] = '{8'h00, 8'h48, 8'hD0, 8'h80}; // tx baud cases
	logic [7:0] te [4] = '{8'h00, 8'h00, 8'h00, 8'h03}; // tx extended divisor
	logic [7:0] dt [4] = '{8'hA5, 8'h35, 8'hC3, 8'h69}; // lsb set: start bit alone
	int bl [4] = '{16, 96, 832, 192}; // tx bit, cycles
	logic [7:0] rb [3] = '{8'h01, 8'h43, 8'h00}; // rx baud cases
	logic [7:0] re [3] = '{8'h00, 8'h00, 8'h05};
	logic [7:0] rxd [3] = '{8'h96, 8'h5A, 8'hE7};
	int rl [3] = '{32, 384, 80}; // rx bit, cycles
	uscb_top dut (.clk_sys, .resetn, .busAddr, .busWrData, .busWr, .busRd, .busRdData,
		.cpuIrqMask, .serialIrq, .rxPin, .txPin, .txPinOwn);
	uscb_remote remote (.clk_sys, .txPin, .bitLen, .rxPin);
	// 200 MHz
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failCount++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic completeRun();
		$display("checks %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : completeRun
	// strobe one cycle, then a quiet cycle so strobes never merge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge clk_sys);
		busWr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	// data looked at only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk_sys);
		busRd <= 1'b0;
		#1 check($sformatf("reg %0d", a), busRdData, exp);
		@(posedge clk_sys);
	endtask : rd
	task automatic irqIs(input logic exp);
		#1 check("irq", serialIrq, exp);
		@(posedge clk_sys);
	endtask : irqIs
	// bounded: a stuck transmitter ends the run
	task automatic waitFrames(input int n);
		for (int k = 0; remote.frames < n; k++)
		begin
			if (k == 60000)
			begin
				failCount++;
				completeRun();
			end
			@(posedge clk_sys);
		end
	endtask : waitFrames
	initial
	begin
		busAddr = 3'h0;
		busWrData = 8'h00;
		busWr = 1'b0;
		busRd = 1'b0;
		cpuIrqMask = 1'b0;
		resetn = 1'b0;
		bitLen = 16;
		checked = 0;
		failCount = 0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rd(3'h0, 8'hC0);
		for (int a = 2; a < 8; a++)
			rd(3'(a), 8'h00);
		wr(3'h3, 8'hFF);
		rd(3'h3, 8'h00);
		irqIs(1'b0);
		$display("test reset done");
		wr(3'h4, 8'h80);
		irqIs(1'b1);
		cpuIrqMask <= 1'b1;
		irqIs(1'b0);
		cpuIrqMask <= 1'b0;
		wr(3'h4, 8'h40);
		irqIs(1'b1);
		wr(3'h4, 8'h30);
		irqIs(1'b0);
		$display("test irq done");
		// status access then data write releases each frame
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h2, br[i]);
			wr(3'h7, te[i]);
			wr(3'h4, 8'h08);
			bitLen = bl[i];
			rd(3'h0, 8'hC0);
			wr(3'h1, dt[i]);
			waitFrames(i + 1);
			check("tx data", remote.gotByte, dt[i]);
			check("tx bit", remote.lowLen, bl[i]);
			repeat (bl[i]) @(posedge clk_sys);
			rd(3'h0, 8'hC0);
			check("frames", remote.frames, i + 1);
		end
		$display("test transmit done");
		wr(3'h7, 8'h00);
		wr(3'h4, 8'h2C);
		// frame plus idle line: 22 bit times
		for (int j = 0; j < 3; j++)
		begin
			wr(3'h2, rb[j]);
			wr(3'h5, re[j]);
			remote.send(rxd[j], rl[j]);
			repeat (rl[j] * 12) @(posedge clk_sys);
			rd(3'h0, 8'hF0);
			irqIs(1'b1);
			rd(3'h1, rxd[j]);
			rd(3'h0, 8'hC0);
			irqIs(1'b0);
		end
		remote.send(8'h11, 80);
		remote.send(8'h22, 80);
		repeat (960) @(posedge clk_sys);
		rd(3'h0, 8'hF8);
		rd(3'h1, 8'h11);
		$display("test receive done");
		// data already received before muting
		wr(3'h4, 8'h2E);
		remote.send(8'h33, 80);
		repeat (960) @(posedge clk_sys);
		rd(3'h0, 8'hC0);
		rd(3'h4, 8'h2C);
		$display("test mute done");
		// clear inside the first break: exactly one more follows
		wr(3'h4, 8'h09);
		repeat (120) @(posedge clk_sys);
		wr(3'h4, 8'h08);
		waitFrames(5);
		check("break", remote.lowLen, 320);
		$display("test break done");
		// tx_on pulsed low mid-frame: an idle frame holds the next word back
		bitLen = 16;
		rd(3'h0, 8'hC0);
		wr(3'h1, 8'h4B);
		repeat (40) @(posedge clk_sys);
		wr(3'h4, 8'h00);
		wr(3'h4, 8'h08);
		rd(3'h0, 8'h80);
		wr(3'h1, 8'hC5);
		repeat (200) @(posedge clk_sys);
		rd(3'h0, 8'h40);
		waitFrames(7);
		check("preamble data", remote.gotByte, 8'hC5);
		check("preamble bit", remote.lowLen, 16);
		$display("test preamble done");
		completeRun();
	end
endmodule : tb_top
